// >>> rcotr_top.sv
`timescale 1ns/10ps
module rcotr_top
(
   input  wire logic       CLK,
   input  wire logic       ARST_N,
   input  wire logic [2:0] BUS_ADDR,
   input  wire logic [7:0] BUS_WDATA,
   input  wire logic       BUS_WR,
   input  wire logic       BUS_RD,
   output logic      [7:0] BUS_RDATA,
   input  wire logic       SPECIAL_MODE,
   input  wire logic       FLASH_TRIM_VALID,
   input  wire logic [15:0] FLASH_TRIM_DATA,
   input  wire logic       PLL_CLOCK_SELECT,
   input  wire logic       PLL_LOCK_SET,
   input  wire logic       OSC_STABLE_SET,
   output logic [9:0]      RC_FREQ_TRIM,
   output logic [3:0]      COARSE_TRIM,
   output logic [5:0]      FINE_TRIM,
   output logic [4:0]      TEMP_COEFF_TRIM,
   output logic            TC_COMP_EN,
   output logic            TC_DIR_POS,
   output logic [3:0]      TC_MAGNITUDE,
   output logic [7:0]      FACTORY_TEST_REG,
   output logic            PLL_LOCK_FLAG,
   output logic            OSCILLATOR_STABLE_FLAG,
   output logic            TRIM_LOADED,
   output logic            IRQ
);
   // ***********************************************************
   // declarations
   // ***********************************************************
   rcotr_pkg::rcotr_load_e state_r;
   rcotr_pkg::rcotr_load_e state_nxt;
   logic [7:0]  trim_hi_r;
   logic [7:0]  trim_hi_nxt;
   logic [7:0]  trim_lo_r;
   logic [7:0]  trim_lo_nxt;
   logic        protect_r;
   logic        protect_nxt;
   logic [7:0]  test_r;
   logic [7:0]  test_nxt;
   logic        lock_r;
   logic        lock_nxt;
   logic        stable_r;
   logic        stable_nxt;
   logic [2:0]  mask_r;
   logic [2:0]  mask_nxt;
   logic [7:0]  rdata_nxt;
   logic [2:0]  int_stat;
   logic [2:0]  int_set;
   logic        int_clr;
   logic        trim_wr;
   logic        trim_ok;
   logic        trim_clear;
   logic        dec_en;
   logic        dec_pos;
   logic [3:0]  dec_mag;
   logic        tc_en_nxt;
   logic        tc_pos_nxt;
   logic [3:0]  tc_mag_nxt;

   function automatic logic is_trim(input logic [2:0] a);
      is_trim = (a == rcotr_pkg::OFS_TRIM_HI) ||
                (a == rcotr_pkg::OFS_TRIM_LO);
   endfunction

   // ***********************************************************
   // write qualification
   // ***********************************************************
   always_comb
   begin
      trim_wr = BUS_WR & is_trim(BUS_ADDR);
      trim_ok = trim_wr & ~protect_r &
                (state_r == rcotr_pkg::RUN); // R03
      trim_clear = trim_wr & PLL_CLOCK_SELECT; // R04
   end

   // ***********************************************************
   // factory load sequence
   // ***********************************************************
   always_comb
   begin
      state_nxt = state_r;
      unique case (state_r)
         rcotr_pkg::LOAD_WAIT:
         begin
            if (FLASH_TRIM_VALID)
               state_nxt = rcotr_pkg::RUN; // R02
         end
         rcotr_pkg::RUN:
         begin
            state_nxt = rcotr_pkg::RUN;
         end
      endcase
   end

   always_ff @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
         state_r <= rcotr_pkg::LOAD_WAIT;
      else
         state_r <= state_nxt;
   end

   // ***********************************************************
   // trim registers
   // ***********************************************************
   always_comb
   begin
      trim_hi_nxt = trim_hi_r;
      trim_lo_nxt = trim_lo_r;
      if (state_r == rcotr_pkg::LOAD_WAIT && FLASH_TRIM_VALID)
      begin
         trim_hi_nxt = FLASH_TRIM_DATA[15:8] & rcotr_pkg::HI_WMASK; // R02
         trim_lo_nxt = FLASH_TRIM_DATA[7:0]; // R02
      end
      else if (trim_ok)
      begin
         if (BUS_ADDR == rcotr_pkg::OFS_TRIM_HI)
            trim_hi_nxt = BUS_WDATA & rcotr_pkg::HI_WMASK; // R12
         else
            trim_lo_nxt = BUS_WDATA;
      end
   end

   always_ff @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         trim_hi_r <= rcotr_pkg::RST_TRIM_HI;
         trim_lo_r <= rcotr_pkg::RST_TRIM_LO;
      end
      else
      begin
         trim_hi_r <= trim_hi_nxt;
         trim_lo_r <= trim_lo_nxt;
      end
   end

   // ***********************************************************
   // protection and factory test registers
   // ***********************************************************
   always_comb
   begin
      protect_nxt = protect_r;
      test_nxt = test_r;
      if (BUS_WR && BUS_ADDR == rcotr_pkg::OFS_PROTECT)
         protect_nxt = (BUS_WDATA != rcotr_pkg::PROTECT_KEY);
      if (BUS_WR && BUS_ADDR == rcotr_pkg::OFS_TEST && SPECIAL_MODE)
         test_nxt = BUS_WDATA; // R01
   end

   always_ff @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         protect_r <= rcotr_pkg::RST_PROTECT;
         test_r <= rcotr_pkg::RST_TEST;
      end
      else
      begin
         protect_r <= protect_nxt;
         test_r <= test_nxt;
      end
   end

   // ***********************************************************
   // lock and oscillator stable flags
   // ***********************************************************
   always_comb
   begin
      lock_nxt = PLL_LOCK_SET | (lock_r & ~trim_clear); // R04
      stable_nxt = OSC_STABLE_SET | (stable_r & ~trim_clear); // R04
   end

   always_ff @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         lock_r <= 1'b0;
         stable_r <= 1'b0;
      end
      else
      begin
         lock_r <= lock_nxt;
         stable_r <= stable_nxt;
      end
   end

   // ***********************************************************
   // temperature compensation decode
   // ***********************************************************
   rcotr_tc_decode u_tc
   (
      .tc        (trim_hi_r[rcotr_pkg::TC_MSB:rcotr_pkg::TC_LSB]),
      .comp_en   (dec_en),
      .dir_pos   (dec_pos),
      .magnitude (dec_mag)
   );

   always_comb
   begin
      tc_en_nxt = dec_en; // R09
      tc_pos_nxt = dec_pos; // R10
      tc_mag_nxt = dec_mag; // R10
   end

   always_ff @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         TC_COMP_EN <= 1'b0;
         TC_DIR_POS <= 1'b0;
         TC_MAGNITUDE <= 4'h0;
      end
      else
      begin
         TC_COMP_EN <= tc_en_nxt;
         TC_DIR_POS <= tc_pos_nxt;
         TC_MAGNITUDE <= tc_mag_nxt;
      end
   end

   // ***********************************************************
   // interrupts
   // ***********************************************************
   always_comb
   begin
      int_set = 3'h0;
      int_set[rcotr_pkg::EV_LOADED] =
         (state_r == rcotr_pkg::LOAD_WAIT) & FLASH_TRIM_VALID;
      int_set[rcotr_pkg::EV_REJECT] = trim_wr & ~trim_ok;
      int_set[rcotr_pkg::EV_FLAGCLR] = trim_clear;
      int_clr = BUS_RD & (BUS_ADDR == rcotr_pkg::OFS_INT_STAT);
      mask_nxt = mask_r;
      if (BUS_WR && BUS_ADDR == rcotr_pkg::OFS_INT_MASK)
         mask_nxt = BUS_WDATA[rcotr_pkg::INT_W-1:0];
   end

   rcotr_sticky u_int
   (
      .clk    (CLK),
      .arst_n (ARST_N),
      .set    (int_set),
      .clr    (int_clr),
      .q      (int_stat)
   );

   always_ff @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
         mask_r <= rcotr_pkg::RST_MASK;
      else
         mask_r <= mask_nxt;
   end

   // ***********************************************************
   // read port
   // ***********************************************************
   always_comb
   begin
      rdata_nxt = 8'h00;
      if (BUS_RD)
      begin
         unique case (BUS_ADDR)
            rcotr_pkg::OFS_TRIM_HI:  rdata_nxt = trim_hi_r; // R03
            rcotr_pkg::OFS_TRIM_LO:  rdata_nxt = trim_lo_r; // R03
            rcotr_pkg::OFS_PROTECT:  rdata_nxt = {7'h00, protect_r};
            rcotr_pkg::OFS_TEST:     rdata_nxt = test_r;
            rcotr_pkg::OFS_FLAGS:    rdata_nxt = {6'h00, stable_r, lock_r};
            rcotr_pkg::OFS_INT_STAT: rdata_nxt = {5'h00, int_stat};
            rcotr_pkg::OFS_INT_MASK: rdata_nxt = {5'h00, mask_r};
            default:                 rdata_nxt = 8'h00;
         endcase
      end
   end

   always_ff @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
         BUS_RDATA <= 8'h00;
      else
         BUS_RDATA <= rdata_nxt;
   end

   // ***********************************************************
   // outputs
   // ***********************************************************
   always_comb
   begin
      RC_FREQ_TRIM = {trim_hi_r[rcotr_pkg::FRQ_HI_MSB:0], trim_lo_r}; // R06
      COARSE_TRIM = RC_FREQ_TRIM[9:rcotr_pkg::COARSE_LSB]; // R07
      FINE_TRIM = RC_FREQ_TRIM[rcotr_pkg::FINE_MSB:0]; // R08
      TEMP_COEFF_TRIM = trim_hi_r[rcotr_pkg::TC_MSB:rcotr_pkg::TC_LSB]; // R05
      FACTORY_TEST_REG = test_r;
      PLL_LOCK_FLAG = lock_r;
      OSCILLATOR_STABLE_FLAG = stable_r;
      TRIM_LOADED = (state_r == rcotr_pkg::RUN);
      IRQ = |(int_stat & mask_r);
   end

   // ***********************************************************
   // checks
   // ***********************************************************
   chk_test_write_mode: assert property ( // R01
      @(posedge CLK) disable iff (!ARST_N)
      BUS_WR && BUS_ADDR == rcotr_pkg::OFS_TEST && !SPECIAL_MODE
      |=> FACTORY_TEST_REG == $past(FACTORY_TEST_REG))
      else $error("test register written outside special mode");

   chk_factory_load: assert property ( // R02
      @(posedge CLK) disable iff (!ARST_N)
      !TRIM_LOADED && FLASH_TRIM_VALID && $past(ARST_N)
      |=> TRIM_LOADED && RC_FREQ_TRIM == $past(FLASH_TRIM_DATA[9:0])
          && TEMP_COEFF_TRIM == $past(FLASH_TRIM_DATA[15:11]))
      else $error("factory trim not loaded");

   chk_protect_blocks: assert property ( // R03
      @(posedge CLK) disable iff (!ARST_N)
      BUS_WR && is_trim(BUS_ADDR) && protect_r && TRIM_LOADED
      |=> $stable(RC_FREQ_TRIM) && $stable(TEMP_COEFF_TRIM))
      else $error("protected trim write took effect");

   chk_trim_readback: assert property ( // R03
      @(posedge CLK) disable iff (!ARST_N)
      BUS_RD && BUS_ADDR == rcotr_pkg::OFS_TRIM_LO && !trim_ok
      |=> BUS_RDATA == $past(RC_FREQ_TRIM[7:0]))
      else $error("trim low readback wrong");

   chk_flags_cleared: assert property ( // R04
      @(posedge CLK) disable iff (!ARST_N)
      BUS_WR && is_trim(BUS_ADDR) && PLL_CLOCK_SELECT
      && !PLL_LOCK_SET && !OSC_STABLE_SET
      |=> !PLL_LOCK_FLAG && !OSCILLATOR_STABLE_FLAG)
      else $error("flags not cleared by trim write");

   chk_tc_field: assert property ( // R05
      @(posedge CLK) disable iff (!ARST_N)
      trim_ok && BUS_ADDR == rcotr_pkg::OFS_TRIM_HI
      |=> TEMP_COEFF_TRIM == $past(BUS_WDATA[7:3]))
      else $error("temperature trim field wrong");

   chk_freq_field: assert property ( // R06
      @(posedge CLK) disable iff (!ARST_N)
      trim_ok && BUS_ADDR == rcotr_pkg::OFS_TRIM_HI
      |=> RC_FREQ_TRIM[9:8] == $past(BUS_WDATA[1:0])
          && COARSE_TRIM[3:2] == $past(BUS_WDATA[1:0])) // R07
      else $error("frequency high bits wrong");

   chk_fine_field: assert property ( // R08
      @(posedge CLK) disable iff (!ARST_N)
      trim_ok && BUS_ADDR == rcotr_pkg::OFS_TRIM_LO
      |=> FINE_TRIM == $past(BUS_WDATA[5:0])
          && COARSE_TRIM[1:0] == $past(BUS_WDATA[7:6]))
      else $error("fine trim field wrong");

   chk_tc_disable: assert property ( // R09
      @(posedge CLK) disable iff (!ARST_N)
      TEMP_COEFF_TRIM[3:0] == 4'h0 && $stable(TEMP_COEFF_TRIM)
      |=> !TC_COMP_EN)
      else $error("compensation left on for nominal code");

   chk_tc_sign: assert property ( // R10
      @(posedge CLK) disable iff (!ARST_N)
      ##1 TC_DIR_POS == $past(TEMP_COEFF_TRIM[4])
      && TC_MAGNITUDE == $past(TEMP_COEFF_TRIM[3:0]))
      else $error("sign or magnitude decode wrong");

   chk_rsvd_zero: assert property ( // R12
      @(posedge CLK) disable iff (!ARST_N)
      BUS_RD && BUS_ADDR == rcotr_pkg::OFS_TRIM_HI
      |=> BUS_RDATA[rcotr_pkg::HI_RSVD] == 1'b0)
      else $error("reserved trim bit reads one");
endmodule

// >>> rcotr_pkg.sv
// Contract
// R01: factory test register takes writes only in special mode.
// R02: on reset release both trim registers load the factory trim from flash.
// R03: trim registers always readable; writes land only while protect is 0.
// R04: trim write while pll select is 1 clears lock and stable flags.
// R05: temperature trim is five bits at 15 to 11, driven to compensation.
// R06: frequency trim is ten bits at 9 to 0, driven to oscillator.
// R07: frequency bits 9 to 6 form the coarse step of about 6 percent.
// R08: frequency bits 5 to 0 form the fine step of about 0.3 percent.
// R09: temperature codes 00000 and 10000 switch compensation off.
// R10: temperature code is sign and magnitude; top bit set means positive.
// R11: software should retrim frequency after changing temperature trim.
// R12: bit 10 of the trim word reads zero and ignores writes.
package rcotr_pkg;
   localparam int AW = 3;
   localparam int DW = 8;
   localparam int INT_W = 3;
   localparam logic [2:0] OFS_TRIM_HI = 3'h0;
   localparam logic [2:0] OFS_TRIM_LO = 3'h1;
   localparam logic [2:0] OFS_PROTECT = 3'h2;
   localparam logic [2:0] OFS_TEST = 3'h3;
   localparam logic [2:0] OFS_FLAGS = 3'h4;
   localparam logic [2:0] OFS_INT_STAT = 3'h5;
   localparam logic [2:0] OFS_INT_MASK = 3'h6;
   // trim high byte layout
   localparam int TC_MSB = 7;
   localparam int TC_LSB = 3;
   localparam int HI_RSVD = 2;
   localparam int FRQ_HI_MSB = 1;
   localparam logic [7:0] HI_WMASK = 8'hFB;
   // frequency field split
   localparam int COARSE_LSB = 6;
   localparam int FINE_MSB = 5;
   // flag and interrupt bit positions
   localparam int FLG_LOCK = 0;
   localparam int FLG_STABLE = 1;
   localparam int EV_LOADED = 0;
   localparam int EV_REJECT = 1;
   localparam int EV_FLAGCLR = 2;
   localparam logic [7:0] PROTECT_KEY = 8'h26;
   localparam logic [7:0] RST_TRIM_HI = 8'h00;
   localparam logic [7:0] RST_TRIM_LO = 8'h00;
   localparam logic [7:0] RST_TEST = 8'h00;
   localparam logic RST_PROTECT = 1'b0;
   localparam logic [INT_W-1:0] RST_MASK = 3'h0;
   typedef enum logic {LOAD_WAIT, RUN} rcotr_load_e;
endpackage

// >>> rcotr_tc_decode.sv
`timescale 1ns/10ps
module rcotr_tc_decode
(
   input  wire logic [4:0] tc,
   output logic            comp_en,
   output logic            dir_pos,
   output logic [3:0]      magnitude
);
   always_comb
   begin
      comp_en = (tc[3:0] != 4'h0); // R09
      dir_pos = tc[4]; // R10
      magnitude = tc[3:0]; // R10
   end
endmodule

// >>> rcotr_sticky.sv
`timescale 1ns/10ps
module rcotr_sticky
(
   input  wire logic                         clk,
   input  wire logic                         arst_n,
   input  wire logic [rcotr_pkg::INT_W-1:0] set,
   input  wire logic                         clr,
   output logic      [rcotr_pkg::INT_W-1:0] q
);
   logic [rcotr_pkg::INT_W-1:0] q_nxt;

   genvar i;
   generate
      for (i = 0; i < rcotr_pkg::INT_W; i++)
      begin : g_bit
         // set wins over a clearing read in the same cycle
         always_comb
         begin
            q_nxt[i] = set[i] | (q[i] & ~clr);
         end
         always_ff @(posedge clk or negedge arst_n)
         begin
            if (!arst_n)
               q[i] <= 1'b0;
            else
               q[i] <= q_nxt[i];
         end
      end
   endgenerate
endmodule

// >>> test_rcotr.sv
`timescale 1ns/10ps
module test_rcotr;
   logic        CLK;
   logic        ARST_N;
   logic [2:0]  BUS_ADDR;
   logic [7:0]  BUS_WDATA;
   logic        BUS_WR;
   logic        BUS_RD;
   logic [7:0]  BUS_RDATA;
   logic        SPECIAL_MODE;
   logic        FLASH_TRIM_VALID;
   logic [15:0] FLASH_TRIM_DATA;
   logic        PLL_CLOCK_SELECT;
   logic        PLL_LOCK_SET;
   logic        OSC_STABLE_SET;
   logic [9:0]  RC_FREQ_TRIM;
   logic [3:0]  COARSE_TRIM;
   logic [5:0]  FINE_TRIM;
   logic [4:0]  TEMP_COEFF_TRIM;
   logic        TC_COMP_EN;
   logic        TC_DIR_POS;
   logic [3:0]  TC_MAGNITUDE;
   logic [7:0]  FACTORY_TEST_REG;
   logic        PLL_LOCK_FLAG;
   logic        OSCILLATOR_STABLE_FLAG;
   logic        TRIM_LOADED;
   logic        IRQ;
   int          n_fail;
   int          checks_done;
   int          cyc;

   rcotr_top dut
   (
      .CLK                    (CLK),
      .ARST_N                 (ARST_N),
      .BUS_ADDR               (BUS_ADDR),
      .BUS_WDATA              (BUS_WDATA),
      .BUS_WR                 (BUS_WR),
      .BUS_RD                 (BUS_RD),
      .BUS_RDATA              (BUS_RDATA),
      .SPECIAL_MODE           (SPECIAL_MODE),
      .FLASH_TRIM_VALID       (FLASH_TRIM_VALID),
      .FLASH_TRIM_DATA        (FLASH_TRIM_DATA),
      .PLL_CLOCK_SELECT       (PLL_CLOCK_SELECT),
      .PLL_LOCK_SET           (PLL_LOCK_SET),
      .OSC_STABLE_SET         (OSC_STABLE_SET),
      .RC_FREQ_TRIM           (RC_FREQ_TRIM),
      .COARSE_TRIM            (COARSE_TRIM),
      .FINE_TRIM              (FINE_TRIM),
      .TEMP_COEFF_TRIM        (TEMP_COEFF_TRIM),
      .TC_COMP_EN             (TC_COMP_EN),
      .TC_DIR_POS             (TC_DIR_POS),
      .TC_MAGNITUDE           (TC_MAGNITUDE),
      .FACTORY_TEST_REG       (FACTORY_TEST_REG),
      .PLL_LOCK_FLAG          (PLL_LOCK_FLAG),
      .OSCILLATOR_STABLE_FLAG (OSCILLATOR_STABLE_FLAG),
      .TRIM_LOADED            (TRIM_LOADED),
      .IRQ                    (IRQ)
   );

   // ************************************************************
   // tasks
   // ************************************************************
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge CLK);
      BUS_ADDR  <= a;
      BUS_WDATA <= d;
      BUS_WR    <= 1'b1;
      BUS_RD    <= 1'b0;
   endtask

   // closes a write; outputs are settled on return except TC_COMP_EN, TC_DIR_POS and TC_MAGNITUDE, which settle one cycle later
   task automatic idle;
      @(posedge CLK);
      BUS_WR <= 1'b0;
      BUS_RD <= 1'b0;
      #1;
   endtask

   task automatic rdchk(input logic [2:0] a, input logic [7:0] e);
      @(posedge CLK);
      BUS_ADDR <= a;
      BUS_RD   <= 1'b1;
      BUS_WR   <= 1'b0;
      @(posedge CLK);
      BUS_RD <= 1'b0;
      #1;
      chk(BUS_RDATA, e);
   endtask

   task automatic end_sim;
      if (n_fail == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // ************************************************************
   // clock and hang guard
   // ************************************************************
   initial
   begin
      CLK = 1'b0;
      forever #10 CLK = ~CLK;
   end

   always @(posedge CLK)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         n_fail++;
         end_sim();
      end
   end

   // ************************************************************
   // main sequence
   // ************************************************************
   initial
   begin
      n_fail = 0;
      checks_done = 0;
      cyc = 0;
      ARST_N = 1'b0;
      BUS_ADDR = 3'h0;
      BUS_WDATA = 8'h00;
      BUS_WR = 1'b0;
      BUS_RD = 1'b0;
      SPECIAL_MODE = 1'b0;
      FLASH_TRIM_VALID = 1'b0;
      FLASH_TRIM_DATA = 16'h0000;
      PLL_CLOCK_SELECT = 1'b0;
      PLL_LOCK_SET = 1'b0;
      OSC_STABLE_SET = 1'b0;
      repeat (12) @(posedge CLK);
      ARST_N <= 1'b1;
      // write before factory load is refused
      wr(rcotr_pkg::OFS_TRIM_LO, 8'h99);
      idle();
      chk(RC_FREQ_TRIM, 16'h0000);
      chk(TRIM_LOADED, 16'h0000);
      @(posedge CLK);
      FLASH_TRIM_DATA <= 16'hAF5A;
      FLASH_TRIM_VALID <= 1'b1;
      repeat (2) @(posedge CLK);
      #1;
      chk(TRIM_LOADED, 16'h0001);
      chk(RC_FREQ_TRIM, 16'h035A);
      chk(COARSE_TRIM, 16'h000D);
      chk(FINE_TRIM, 16'h001A);
      chk(TEMP_COEFF_TRIM, 16'h0015);
      chk({TC_COMP_EN, TC_DIR_POS, TC_MAGNITUDE}, 16'h0035);
      chk(IRQ, 16'h0000);
      @(posedge CLK);
      FLASH_TRIM_DATA <= 16'h0000;
      repeat (2) @(posedge CLK);
      #1;
      chk(RC_FREQ_TRIM, 16'h035A);
      rdchk(rcotr_pkg::OFS_TRIM_HI, 8'hAB);
      rdchk(rcotr_pkg::OFS_TRIM_LO, 8'h5A);
      @(posedge CLK);
      #1;
      chk(BUS_RDATA, 16'h0000);
      // interrupt: load done and refused write are pending
      wr(rcotr_pkg::OFS_INT_MASK, 8'h07);
      idle();
      chk(IRQ, 16'h0001);
      rdchk(rcotr_pkg::OFS_INT_MASK, 8'h07);
      rdchk(rcotr_pkg::OFS_INT_STAT, 8'h03);
      chk(IRQ, 16'h0000);
      rdchk(rcotr_pkg::OFS_INT_STAT, 8'h00);
      // back-to-back writes, unused bit 10
      wr(rcotr_pkg::OFS_TRIM_HI, 8'hFF);
      wr(rcotr_pkg::OFS_TRIM_LO, 8'hC5);
      idle();
      rdchk(rcotr_pkg::OFS_TRIM_HI, 8'hFB);
      chk(RC_FREQ_TRIM, 16'h03C5);
      chk(COARSE_TRIM, 16'h000F);
      chk(FINE_TRIM, 16'h0005);
      // every temperature code
      for (int i = 0; i < 32; i++)
      begin
         wr(rcotr_pkg::OFS_TRIM_HI, {i[4:0], 3'b011});
         idle();
         chk(TEMP_COEFF_TRIM, i[4:0]);
         @(posedge CLK);
         #1;
         chk(TC_COMP_EN, i[3:0] != 4'h0);
         chk(TC_DIR_POS, i[4]);
         chk(TC_MAGNITUDE, i[3:0]);
      end
      wr(rcotr_pkg::OFS_TRIM_LO, 8'hC5);
      // protection
      wr(rcotr_pkg::OFS_PROTECT, 8'h11);
      idle();
      rdchk(rcotr_pkg::OFS_PROTECT, 8'h01);
      wr(rcotr_pkg::OFS_TRIM_LO, 8'h77);
      idle();
      rdchk(rcotr_pkg::OFS_TRIM_LO, 8'hC5);
      rdchk(rcotr_pkg::OFS_INT_STAT, 8'h02);
      wr(rcotr_pkg::OFS_PROTECT, 8'h26);
      wr(rcotr_pkg::OFS_TRIM_LO, 8'h77);
      idle();
      rdchk(rcotr_pkg::OFS_PROTECT, 8'h00);
      rdchk(rcotr_pkg::OFS_TRIM_LO, 8'h77);
      // flags cleared only by trim writes under pll select
      @(posedge CLK);
      PLL_LOCK_SET <= 1'b1;
      OSC_STABLE_SET <= 1'b1;
      @(posedge CLK);
      PLL_LOCK_SET <= 1'b0;
      OSC_STABLE_SET <= 1'b0;
      rdchk(rcotr_pkg::OFS_FLAGS, 8'h03);
      wr(rcotr_pkg::OFS_TRIM_LO, 8'h11);
      idle();
      rdchk(rcotr_pkg::OFS_FLAGS, 8'h03);
      wr(rcotr_pkg::OFS_PROTECT, 8'h01);
      PLL_CLOCK_SELECT <= 1'b1;
      wr(rcotr_pkg::OFS_TRIM_HI, 8'h00);
      idle();
      chk({PLL_LOCK_FLAG, OSCILLATOR_STABLE_FLAG}, 16'h0000);
      rdchk(rcotr_pkg::OFS_TRIM_HI, 8'hFB);
      rdchk(rcotr_pkg::OFS_INT_STAT, 8'h06);
      // a set beside a clearing write wins
      wr(rcotr_pkg::OFS_TRIM_LO, 8'h26);
      PLL_LOCK_SET <= 1'b1;
      @(posedge CLK);
      PLL_LOCK_SET <= 1'b0;
      BUS_WR <= 1'b0;
      #1;
      chk(PLL_LOCK_FLAG, 16'h0001);
      // factory test register
      wr(rcotr_pkg::OFS_TEST, 8'h5C);
      idle();
      chk(FACTORY_TEST_REG, 16'h0000);
      rdchk(rcotr_pkg::OFS_TEST, 8'h00);
      wr(rcotr_pkg::OFS_TEST, 8'h5C);
      SPECIAL_MODE <= 1'b1;
      idle();
      chk(FACTORY_TEST_REG, 16'h005C);
      rdchk(rcotr_pkg::OFS_TEST, 8'h5C);
      wr(3'h7, 8'hFF);
      idle();
      rdchk(3'h7, 8'h00);
      // second reset reloads the factory trim
      @(posedge CLK);
      ARST_N <= 1'b0;
      #1;
      chk({RC_FREQ_TRIM, TRIM_LOADED, IRQ}, 16'h0000);
      chk(FACTORY_TEST_REG, 16'h0000);
      repeat (2) @(posedge CLK);
      FLASH_TRIM_DATA <= 16'h1234;
      ARST_N <= 1'b1;
      repeat (3) @(posedge CLK);
      #1;
      chk(RC_FREQ_TRIM, 16'h0234);
      chk(TEMP_COEFF_TRIM, 16'h0002);
      rdchk(rcotr_pkg::OFS_PROTECT, 8'h00);
      end_sim();
   end
endmodule
